// [design/mpl_pkg.sv]
package mpl_pkg;
  // clock rate
  localparam int CLK_MHZ = 100;
  // bit period limits in ns and the per-frame drift allowance
  localparam int BIT_FAST_NS = 9500;
  localparam int BIT_SLOW_NS = 257000;
  localparam int DRIFT_PCT = 11;
  localparam logic [15:0] BIT_PERIOD_LO_CYC = 16'(BIT_FAST_NS * (100 - DRIFT_PCT) / 100 * CLK_MHZ / 1000);
  localparam logic [15:0] BIT_PERIOD_HI_CYC = 16'(BIT_SLOW_NS * (100 + DRIFT_PCT) / 100 * CLK_MHZ / 1000);
  localparam logic [14:0] HALF_MIN_CYC = 15'(BIT_FAST_NS * CLK_MHZ / 2000);
  localparam logic [14:0] HALF_MAX_CYC = 15'(BIT_SLOW_NS * CLK_MHZ / 2000);
  // access code deadline after power-up
  localparam int ACC_DEADLINE_MS = 70;
  localparam int ACC_DEADLINE_CYC = ACC_DEADLINE_MS * 1000 * CLK_MHZ;
  localparam int ACC_CNT_W = 23;
  // response delays in us
  localparam int WOUT_DIS_US = 9;
  localparam int WOUT_EN_US = 6;
  localparam int ROUT_LOW_US = 45;
  localparam int START_READ_US = 50;
  localparam int ROUT_EN_US = 45;
  localparam int OUT_SW_US = 5;
  localparam int PULSE_SETUP_US = 40;
  localparam int PROG_PULSE_US = 50;
  localparam int PROG_GAP_US = 50;
  localparam int ACK_TO_US = 300;
  localparam logic [15:0] WOUT_DIS_CYC = 16'(WOUT_DIS_US * CLK_MHZ);
  localparam logic [15:0] WOUT_EN_CYC = 16'(WOUT_EN_US * CLK_MHZ);
  localparam logic [15:0] ROUT_LOW_CYC = 16'(ROUT_LOW_US * CLK_MHZ);
  localparam logic [15:0] LOW_LEAD_CYC = 16'((START_READ_US - ROUT_LOW_US) * CLK_MHZ);
  localparam logic [15:0] ROUT_EN_CYC = 16'(ROUT_EN_US * CLK_MHZ);
  localparam logic [15:0] OUT_SW_CYC = 16'(OUT_SW_US * CLK_MHZ);
  localparam logic [15:0] PULSE_SETUP_CYC = 16'(PULSE_SETUP_US * CLK_MHZ);
  localparam logic [15:0] PROG_PULSE_CYC = 16'(PROG_PULSE_US * CLK_MHZ);
  localparam logic [15:0] PROG_GAP_CYC = 16'(PROG_GAP_US * CLK_MHZ);
  localparam logic [15:0] ACK_TO_CYC = 16'(ACK_TO_US * CLK_MHZ);
  // frame layout
  localparam int ADDR_W = 6;
  localparam int WR_DATA_W = 16;
  localparam int ACC_DATA_W = 30;
  localparam int RD_DATA_W = 16;
  localparam logic [5:0] SYNC_BITS = 6'd2;
  localparam logic [5:0] HDR_LAST = 6'd8;
  localparam logic [5:0] LEN_SHORT = 6'd12;
  localparam logic [5:0] LEN_WR = 6'd28;
  localparam logic [5:0] LEN_ACC = 6'd42;
  localparam logic [5:0] LEN_ACK = 6'd21;
  localparam logic [5:0] LEN_OVH = 6'd5;
  localparam logic [5:0] FRAME_MAX = 6'd42;
  localparam logic [2:0] CRC_INIT = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_ACCESS = 6'h24;
  localparam logic [ADDR_W-1:0] ADDR_DIS = 6'h3e;
  localparam logic [ADDR_W-1:0] ADDR_EN = 6'h3f;
  // arbitrary unlock code value
  localparam logic [ACC_DATA_W-1:0] ACCESS_CODE = 30'h15a5a5a5;

  typedef enum logic [2:0] {
    CMD_READ = 3'b000,
    CMD_WRITE = 3'b001,
    CMD_ACCESS = 3'b010,
    CMD_DIS = 3'b011,
    CMD_EN = 3'b100
  } mpl_cmd_t;

  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_SYNC = 2'b01, RX_BITS = 2'b10} mpl_rx_t;

  typedef enum logic [2:0] {
    OS_IDLE = 3'b000, OS_DELAY = 3'b001, OS_LOW = 3'b010,
    OS_TX = 3'b011, OS_REST = 3'b100, OS_PROG = 3'b101
  } mpl_os_t;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b000, CS_TX = 3'b001, CS_SETUP = 3'b010, CS_PULSE = 3'b011,
    CS_GAP = 3'b100, CS_ACK = 3'b101, CS_GUARD = 3'b110
  } mpl_cs_t;

  // one step of the x^3+x+1 check register
  function automatic logic [2:0] crc3_step(input logic [2:0] c, input logic b);
    logic fb;
    fb = c[2] ^ b;
    return {c[1], c[0] ^ fb, fb};
  endfunction

  // check value over the low n bits of v, msb first
  function automatic logic [2:0] crc3_calc(input logic [39:0] v, input logic [5:0] n);
    logic [2:0] c;
    c = CRC_INIT;
    for (int i = 39; i >= 0; i--) begin
      if (i < int'(n)) c = crc3_step(c, v[i]);
    end
    return c;
  endfunction
endpackage

// [design/mpl_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface mpl_if;
  logic vcc_line;
  logic dev_out;
  logic dev_oe;
  logic ctl_out;
  logic ctl_oe;
  logic out_line;
  // resolved output pin, pulled low when nobody drives, so a programming pulse shows as a high strobe
  assign out_line = dev_oe ? dev_out : (ctl_oe ? ctl_out : 1'b0);
  modport dev (input vcc_line, input out_line, output dev_out, output dev_oe);
  modport ctl (output vcc_line, output ctl_out, output ctl_oe, input out_line);
endinterface
`default_nettype wire

// [design/mpl_dev.sv]
`timescale 1ns/10ps
`default_nettype none
// How it works
// - access code due within 70 ms
// - frames accepted from 4 to 100 kbps
// - bit period 250 us slow, 10 us fast
// - decode despite 11 percent drift per frame
// - write: output high impedance after about 9 us
// - controller waits two bits after second pulse
// - output normal again 6 us after last pulse
// - controller waits two and a half bits after acknowledge
// - output held low 45 us before acknowledge
// - acknowledge starts about 50 us after read
// - output normal 45 us after acknowledge
// - disable command: high impedance after 5 us
// - enable command: normal output after 5 us
// - controller waits 40 us before programming pulse
// - response timed from last mid-bit edge
// - Manchester: rising zero, falling one, msb first
// - three-bit check x^3+x+1, seeded all ones
// - frame: sync 00, rw, address, data, check
// - only read commands get an answer
module mpl_dev
  import mpl_pkg::*;
#(
  parameter int ACC_DEADLINE = ACC_DEADLINE_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // link
  mpl_if.dev lnk,
  // sensor output level in normal operation
  input wire logic sens_out_i,
  // register read port
  output logic [ADDR_W-1:0] rd_addr_o,
  output logic rd_req_o,
  input wire logic [RD_DATA_W-1:0] rd_data_i,
  // register write port
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [WR_DATA_W-1:0] wr_data_o,
  output logic wr_valid_o,
  // status
  output logic unlocked_o,
  output logic out_dis_o,
  output logic crc_err_o
);
  logic vcc_s1_r, vcc_s2_r, vcc_d_r, pin_s1_r, pin_s2_r, pin_d_r;
  logic vcc_edge, pin_fall, pin_rise, mid, bval, crc_ok, rx_done, acc_go, expired;
  logic [2:0] crc_nxt;
  logic [5:0] flen;
  mpl_rx_t rx_st_r;
  logic [15:0] cnt_r, bit_period_r, quarter;
  logic [5:0] nbit_r;
  logic [36:0] sh_r;
  logic [2:0] crc_r;
  logic [6:0] hdr_r;
  mpl_os_t os_r;
  mpl_cmd_t act_r;
  logic [15:0] dly_r, hcnt_r;
  logic [20:0] tx_r;
  logic [4:0] ntx_r;
  logic ph_r, npulse_r, arm_r, dis_r, unl_r, out_r, oe_r;
  logic [ACC_CNT_W-1:0] acc_cnt_r;

  // two-stage synchronisers for both pins, plus a delayed copy for edges
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vcc_s1_r <= 1'b1;
      vcc_s2_r <= 1'b1;
      vcc_d_r <= 1'b1;
      pin_s1_r <= 1'b0; // idle level of the pulled-down pin
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      vcc_s1_r <= lnk.vcc_line;
      vcc_s2_r <= vcc_s1_r;
      vcc_d_r <= vcc_s2_r;
      pin_s1_r <= lnk.out_line;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign vcc_edge = vcc_s2_r ^ vcc_d_r;
  assign pin_fall = pin_d_r & ~pin_s2_r;
  assign pin_rise = ~pin_d_r & pin_s2_r;
  assign quarter = bit_period_r >> 2;
  // mid-bit edge window opens at 3/4 of the measured period
  assign mid = vcc_edge && (cnt_r >= bit_period_r - quarter);
  assign bval = ~vcc_s2_r;
  assign crc_nxt = crc3_step(crc_r, bval);
  assign crc_ok = (crc_nxt == 3'h0);
  assign expired = (acc_cnt_r == ACC_CNT_W'(ACC_DEADLINE));

  // frame length follows from rw bit and address
  always_comb begin
    flen = LEN_WR;
    if (hdr_r[6]) begin
      flen = LEN_SHORT;
    end else if (hdr_r[5:0] == ADDR_ACCESS) begin
      flen = LEN_ACC;
    end else if (hdr_r[5:0] == ADDR_DIS || hdr_r[5:0] == ADDR_EN) begin
      flen = LEN_SHORT;
    end
  end

  // frame ends on the last mid-bit edge, not after the trailing half
  assign rx_done = (rx_st_r == RX_BITS) && mid && (nbit_r > HDR_LAST) && (nbit_r + 6'd1 == flen);
  assign acc_go = rx_done && crc_ok && (os_r == OS_IDLE);

  // receiver: measure period on sync, then track mid-bit edges
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st_r <= RX_IDLE;
      cnt_r <= 16'h0;
      bit_period_r <= BIT_PERIOD_HI_CYC;
      nbit_r <= 6'h0;
      sh_r <= 37'h0;
      crc_r <= CRC_INIT;
      hdr_r <= 7'h0;
    end else begin
      cnt_r <= cnt_r + 16'h1;
      unique case (rx_st_r)
        RX_IDLE: begin
          if (vcc_edge && !vcc_s2_r) begin
            rx_st_r <= RX_SYNC;
            cnt_r <= 16'h0;
          end
        end
        RX_SYNC: begin
          if (cnt_r > BIT_PERIOD_HI_CYC) begin
            rx_st_r <= RX_IDLE;
          end else if (vcc_edge && !vcc_s2_r) begin
            // second falling edge closes the first sync cell
            if (cnt_r < BIT_PERIOD_LO_CYC) begin
              rx_st_r <= RX_IDLE;
            end else begin
              bit_period_r <= cnt_r;
              cnt_r <= cnt_r >> 1;
              nbit_r <= 6'h1;
              crc_r <= CRC_INIT;
              rx_st_r <= RX_BITS;
            end
          end
        end
        RX_BITS: begin
          if (cnt_r > bit_period_r + quarter) begin
            rx_st_r <= RX_IDLE;
          end else if (mid) begin
            cnt_r <= 16'h0;
            nbit_r <= nbit_r + 6'h1;
            if (nbit_r < SYNC_BITS) begin
              if (bval) rx_st_r <= RX_IDLE;
            end else begin
              sh_r <= {sh_r[35:0], bval};
              crc_r <= crc_nxt;
              if (nbit_r == HDR_LAST) hdr_r <= {sh_r[5:0], bval};
              if (rx_done) rx_st_r <= RX_IDLE;
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // deadline counter from reset release
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_cnt_r <= '0;
    end else if (!expired) begin
      acc_cnt_r <= acc_cnt_r + 1'b1;
    end
  end

  // command handling and output sequencing
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      os_r <= OS_IDLE;
      act_r <= CMD_READ;
      dly_r <= 16'h0;
      hcnt_r <= 16'h0;
      tx_r <= 21'h0;
      ntx_r <= 5'h0;
      ph_r <= 1'b0;
      npulse_r <= 1'b0;
      arm_r <= 1'b0;
      dis_r <= 1'b0;
      unl_r <= 1'b0;
      rd_req_o <= 1'b0;
      rd_addr_o <= '0;
      wr_valid_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end else begin
      rd_req_o <= 1'b0;
      wr_valid_o <= 1'b0;
      if (dly_r != 16'h0) dly_r <= dly_r - 16'h1;
      unique case (os_r)
        OS_IDLE: begin
          if (acc_go && !hdr_r[6] && hdr_r[5:0] == ADDR_ACCESS) begin
            // unlock only before the deadline runs out
            if (sh_r[ACC_DATA_W+1:2] == ACCESS_CODE && !expired) unl_r <= 1'b1;
          end else if (acc_go && unl_r) begin
            os_r <= OS_DELAY;
            if (hdr_r[6]) begin
              act_r <= CMD_READ;
              rd_req_o <= 1'b1;
              rd_addr_o <= hdr_r[5:0];
              dly_r <= LOW_LEAD_CYC + quarter;
            end else if (hdr_r[5:0] == ADDR_DIS || hdr_r[5:0] == ADDR_EN) begin
              act_r <= (hdr_r[5:0] == ADDR_DIS) ? CMD_DIS : CMD_EN;
              dly_r <= OUT_SW_CYC + quarter;
            end else begin
              act_r <= CMD_WRITE;
              wr_valid_o <= 1'b1;
              wr_addr_o <= hdr_r[5:0];
              wr_data_o <= sh_r[WR_DATA_W+1:2];
              dly_r <= WOUT_DIS_CYC + quarter;
            end
          end
        end
        OS_DELAY: begin
          if (dly_r == 16'h0) begin
            unique case (act_r)
              CMD_READ: begin
                os_r <= OS_LOW;
                dly_r <= ROUT_LOW_CYC;
              end
              CMD_WRITE: begin
                os_r <= OS_PROG;
                npulse_r <= 1'b0;
                arm_r <= 1'b0;
              end
              CMD_DIS: begin
                dis_r <= 1'b1;
                os_r <= OS_IDLE;
              end
              default: begin
                dis_r <= 1'b0;
                os_r <= OS_IDLE;
              end
            endcase
          end
        end
        OS_LOW: begin
          if (dly_r == 16'h0) begin
            os_r <= OS_TX;
            tx_r <= {2'b00, rd_data_i, crc3_calc(40'(rd_data_i), 6'(RD_DATA_W))};
            ntx_r <= 5'h0;
            ph_r <= 1'b0;
            hcnt_r <= (bit_period_r >> 1) - 16'h1;
          end
        end
        OS_TX: begin
          hcnt_r <= hcnt_r - 16'h1;
          if (hcnt_r == 16'h0) begin
            hcnt_r <= (bit_period_r >> 1) - 16'h1;
            ph_r <= ~ph_r;
            if (ph_r) begin
              tx_r <= {tx_r[19:0], 1'b0};
              ntx_r <= ntx_r + 5'h1;
              if (ntx_r == 5'(LEN_ACK - 6'h1)) begin
                os_r <= OS_REST;
                dly_r <= ROUT_EN_CYC;
              end
            end
          end
        end
        OS_PROG: begin
          // count pulse ends; a fall counts only after a rise, so our own release of the pin is ignored
          if (pin_rise) arm_r <= 1'b1;
          if (pin_fall && arm_r) begin
            arm_r <= 1'b0;
            npulse_r <= 1'b1;
            if (npulse_r) begin
              os_r <= OS_REST;
              dly_r <= WOUT_EN_CYC;
            end
          end
        end
        OS_REST: begin
          if (dly_r == 16'h0) os_r <= OS_IDLE;
        end
        default: os_r <= OS_IDLE;
      endcase
    end
  end

  // pin drive by output state
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      unique case (os_r)
        OS_IDLE, OS_DELAY: begin
          out_r <= sens_out_i;
          oe_r <= ~dis_r;
        end
        OS_LOW: begin
          out_r <= 1'b0;
          oe_r <= 1'b1;
        end
        OS_TX: begin
          out_r <= tx_r[20] ^ ph_r;
          oe_r <= 1'b1;
        end
        default: begin
          out_r <= 1'b0;
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign lnk.dev_out = out_r;
  assign lnk.dev_oe = oe_r;
  assign unlocked_o = unl_r;
  assign out_dis_o = dis_r;
  assign crc_err_o = 1'b0 | (rx_done && !crc_ok);
endmodule
`default_nettype wire

// [design/mpl_ctl.sv]
`timescale 1ns/10ps
`default_nettype none
module mpl_ctl
  import mpl_pkg::*;
#(
  parameter int ACC_DEADLINE = ACC_DEADLINE_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // link
  mpl_if.ctl lnk,
  // command request
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire mpl_cmd_t cmd_kind_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [ACC_DATA_W-1:0] cmd_data_i,
  input wire logic [14:0] half_bit_i,
  // read answer
  output logic rd_valid_o,
  output logic [RD_DATA_W-1:0] rd_data_o,
  output logic rd_err_o,
  // access code sent too late
  output logic acc_late_o
);
  logic pin_s1_r, pin_s2_r, pin_d_r, pin_edge, mid, bval;
  logic [14:0] half, half_r;
  logic [15:0] bit_period, cnt_r;
  logic [36:0] pl;
  logic [5:0] len;
  logic [2:0] crc, rcrc_r, rcrc_nxt;
  logic [39:0] body;
  mpl_cs_t cs_r;
  mpl_cmd_t kind_r;
  logic [41:0] tx_r;
  logic [5:0] nleft_r;
  logic [4:0] nbit_r;
  logic [17:0] rsh_r;
  logic ph_r, npulse_r, rx_on_r, vcc_r, out_r, oe_r;
  logic [ACC_CNT_W-1:0] acc_cnt_r;

  // output pin synchroniser
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_r <= 1'b0; // idle level of the pulled-down pin
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      pin_s1_r <= lnk.out_line;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // half period clamped to the legal bit-rate range
  assign half = (half_bit_i < HALF_MIN_CYC) ? HALF_MIN_CYC :
                (half_bit_i > HALF_MAX_CYC) ? HALF_MAX_CYC : half_bit_i;
  assign bit_period = {half_r, 1'b0};
  assign pin_edge = pin_s2_r ^ pin_d_r;
  assign mid = pin_edge && (cnt_r >= bit_period - (bit_period >> 2));
  assign bval = ~pin_s2_r;
  assign rcrc_nxt = crc3_step(rcrc_r, bval);
  assign cmd_ready_o = (cs_r == CS_IDLE);

  // frame builder: payload, check value, left aligned behind sync
  always_comb begin
    pl = 37'({cmd_kind_i == CMD_READ, cmd_addr_i});
    len = LEN_SHORT;
    unique case (cmd_kind_i)
      CMD_WRITE: begin
        pl = 37'({1'b0, cmd_addr_i, cmd_data_i[WR_DATA_W-1:0]});
        len = LEN_WR;
      end
      CMD_ACCESS: begin
        pl = {1'b0, ADDR_ACCESS, cmd_data_i};
        len = LEN_ACC;
      end
      CMD_DIS: pl = 37'({1'b0, ADDR_DIS});
      CMD_EN: pl = 37'({1'b0, ADDR_EN});
      default: pl = 37'({1'b1, cmd_addr_i});
    endcase
    crc = crc3_calc(40'(pl), len - LEN_OVH);
    body = {pl, crc} << (FRAME_MAX - len);
  end

  // deadline counter from reset release
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_cnt_r <= '0;
    end else if (acc_cnt_r != ACC_CNT_W'(ACC_DEADLINE)) begin
      acc_cnt_r <= acc_cnt_r + 1'b1;
    end
  end

  // command sequencer
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_r <= CS_IDLE;
      kind_r <= CMD_READ;
      half_r <= HALF_MAX_CYC;
      cnt_r <= 16'h0;
      tx_r <= 42'h0;
      nleft_r <= 6'h0;
      ph_r <= 1'b0;
      npulse_r <= 1'b0;
      rx_on_r <= 1'b0;
      nbit_r <= 5'h0;
      rsh_r <= 18'h0;
      rcrc_r <= CRC_INIT;
      vcc_r <= 1'b1;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_err_o <= 1'b0;
      rd_data_o <= '0;
      acc_late_o <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      if (cnt_r != 16'h0) cnt_r <= cnt_r - 16'h1;
      unique case (cs_r)
        CS_IDLE: begin
          if (cmd_valid_i) begin
            cs_r <= CS_TX;
            kind_r <= cmd_kind_i;
            half_r <= half;
            tx_r <= {2'b00, body};
            nleft_r <= len;
            ph_r <= 1'b0;
            vcc_r <= 1'b0; // first half of sync zero
            cnt_r <= 16'(half) - 16'h1;
          end
        end
        CS_TX: begin
          if (cnt_r == 16'h0) begin
            cnt_r <= 16'(half_r) - 16'h1;
            if (!ph_r) begin
              ph_r <= 1'b1;
              vcc_r <= ~tx_r[41];
            end else if (nleft_r == 6'h1) begin
              vcc_r <= 1'b1;
              if (kind_r == CMD_ACCESS && acc_cnt_r == ACC_CNT_W'(ACC_DEADLINE)) acc_late_o <= 1'b1;
              unique case (kind_r)
                CMD_WRITE: begin
                  cs_r <= CS_SETUP;
                  npulse_r <= 1'b0;
                  cnt_r <= PULSE_SETUP_CYC;
                end
                CMD_READ: begin
                  cs_r <= CS_ACK;
                  rx_on_r <= 1'b0;
                  cnt_r <= 16'h0;
                end
                default: begin
                  cs_r <= CS_GUARD;
                  cnt_r <= {bit_period[14:0], 1'b0};
                end
              endcase
            end else begin
              ph_r <= 1'b0;
              tx_r <= {tx_r[40:0], 1'b0};
              nleft_r <= nleft_r - 6'h1;
              vcc_r <= tx_r[40];
            end
          end
        end
        CS_SETUP, CS_GAP: begin
          if (cnt_r == 16'h0) begin
            cs_r <= CS_PULSE;
            out_r <= 1'b1;
            oe_r <= 1'b1;
            cnt_r <= PROG_PULSE_CYC;
          end
        end
        CS_PULSE: begin
          if (cnt_r == 16'h0) begin
            out_r <= 1'b0;
            oe_r <= 1'b0;
            npulse_r <= 1'b1;
            cs_r <= npulse_r ? CS_GUARD : CS_GAP;
            cnt_r <= npulse_r ? {bit_period[14:0], 1'b0} : PROG_GAP_CYC;
          end
        end
        CS_ACK: begin
          // counts up here: time since the last mid-bit edge
          cnt_r <= cnt_r + 16'h1;
          if (cnt_r > ACK_TO_CYC + bit_period) begin
            rd_valid_o <= 1'b1;
            rd_err_o <= 1'b1;
            cs_r <= CS_GUARD;
            cnt_r <= {bit_period[14:0], 1'b0};
          end else if (!rx_on_r && pin_edge && pin_s2_r) begin
            rx_on_r <= 1'b1; // mid edge of first sync bit
            cnt_r <= 16'h0;
            nbit_r <= 5'h1;
            rcrc_r <= CRC_INIT;
          end else if (rx_on_r && mid) begin
            cnt_r <= 16'h0;
            nbit_r <= nbit_r + 5'h1;
            if (nbit_r >= 5'(SYNC_BITS)) begin
              rsh_r <= {rsh_r[16:0], bval};
              rcrc_r <= rcrc_nxt;
            end
            if ((nbit_r < 5'(SYNC_BITS) && bval) || nbit_r == 5'(LEN_ACK - 6'h1)) begin
              rd_valid_o <= 1'b1;
              rd_err_o <= bval && nbit_r < 5'(SYNC_BITS) || rcrc_nxt != 3'h0;
              rd_data_o <= rsh_r[17:2];
              cs_r <= CS_GUARD;
              cnt_r <= {bit_period[14:0], 1'b0} + {1'b0, bit_period[15:1]}; // 2.5 bits from the mid edge, no overflow
            end
          end
        end
        CS_GUARD: begin
          if (cnt_r == 16'h0) cs_r <= CS_IDLE;
        end
        default: cs_r <= CS_IDLE;
      endcase
    end
  end

  assign lnk.vcc_line = vcc_r;
  assign lnk.ctl_out = out_r;
  assign lnk.ctl_oe = oe_r;
endmodule
`default_nettype wire

// [verif/mpl_link_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module mpl_link_properties (
  // link signals
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic vcc_line,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic ctl_oe
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic [15:0] gap_r;
  logic [15:0] lo_r;
  logic [15:0] wt_r;
  logic np_r;
  // cycles since the supply line last moved, saturating
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) gap_r <= 16'hffff;
    else if ($changed(vcc_line)) gap_r <= 16'h0;
    else if (gap_r != 16'hffff) gap_r <= gap_r + 16'h1;
  end
  // length of the present driven-low run on the output
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) lo_r <= 16'h0;
    else if (dev_oe && !dev_out) lo_r <= lo_r + 16'h1;
    else lo_r <= 16'h0;
  end
  // time from the second pulse end until the device drives again
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      np_r <= 1'b0;
      wt_r <= 16'h0;
    end else begin
      if ($fell(ctl_oe)) np_r <= !np_r;
      if ($fell(ctl_oe) && np_r) wt_r <= 16'h1;
      else if (wt_r != 16'h0 && !dev_oe) wt_r <= wt_r + 16'h1;
      else wt_r <= 16'h0;
    end
  end
  property p_half_min;
    $changed(vcc_line) |-> gap_r >= 16'd470;
  endproperty
  a_half_min: assert property (p_half_min) else $error("supply edges too close");
  property p_sync_low;
    $fell(vcc_line) |-> !vcc_line [*8];
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("low half too short");
  property p_pulse_hiz;
    ctl_oe |-> !dev_oe;
  endproperty
  a_pulse_hiz: assert property (p_pulse_hiz) else $error("device drives during pulse");
  property p_pulse_setup;
    $rose(ctl_oe) |-> gap_r >= 16'd3995;
  endproperty
  a_pulse_setup: assert property (p_pulse_setup) else $error("pulse setup short");
  property p_pulse_gap;
    $fell(ctl_oe) |-> vcc_line [*8];
  endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("frame right after pulse");
  property p_wr_restore;
    wt_r <= 16'd6000;
  endproperty
  a_wr_restore: assert property (p_wr_restore) else $error("output restore late");
  property p_low_run;
    lo_r <= 16'd6000;
  endproperty
  a_low_run: assert property (p_low_run) else $error("output low too long");
  property p_out_switch;
    $changed(dev_oe) |-> gap_r >= 16'd100;
  endproperty
  a_out_switch: assert property (p_out_switch) else $error("output switched early");
endmodule
`default_nettype wire

// [verif/manchester_prog_link_timing_test.sv]
`timescale 1ns/10ps
`default_nettype none
module manchester_prog_link_timing_test import mpl_pkg::*; ();
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cmd_valid = 1'b0;
  mpl_cmd_t cmd_kind = CMD_READ;
  logic [ADDR_W-1:0] cmd_addr = 6'h0;
  logic [ACC_DATA_W-1:0] cmd_data = 30'h0;
  logic [14:0] half_bit = 15'h1f4;
  logic [RD_DATA_W-1:0] rd_word = 16'h0;
  logic cmd_ready, rd_valid, rd_err, acc_late, unlocked, out_dis, rd_req, wr_valid, crc_err;
  logic [RD_DATA_W-1:0] rd_data;
  logic [ADDR_W-1:0] rd_addr, wr_addr;
  logic [WR_DATA_W-1:0] wr_data;
  int error_cnt = 0;
  int check_count = 0;
  int n_ack = 0;
  int n_rd = 0;
  int n_wr = 0;
  int n_crc = 0;
  mpl_if i_mpl_if ();
  mpl_dev #(.ACC_DEADLINE(60000)) i_mpl_dev (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .lnk(i_mpl_if.dev),
    .sens_out_i(1'b1), .rd_addr_o(rd_addr), .rd_req_o(rd_req), .rd_data_i(rd_word), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .wr_valid_o(wr_valid), .unlocked_o(unlocked), .out_dis_o(out_dis), .crc_err_o(crc_err));
  mpl_ctl #(.ACC_DEADLINE(60000)) i_mpl_ctl (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .lnk(i_mpl_if.ctl),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_kind_i(cmd_kind), .cmd_addr_i(cmd_addr),
    .cmd_data_i(cmd_data), .half_bit_i(half_bit), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .rd_err_o(rd_err), .acc_late_o(acc_late));
  mpl_link_properties i_mpl_link_properties (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .vcc_line(i_mpl_if.vcc_line), .dev_out(i_mpl_if.dev_out), .dev_oe(i_mpl_if.dev_oe),
    .ctl_oe(i_mpl_if.ctl_oe));
  // 100 MHz clock
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // count answer frames, accepted reads and writes, and frames failing the check
  always @(negedge clk_sys_i) begin
    if (rd_valid === 1'b1) n_ack++;
    if (rd_req === 1'b1) n_rd++;
    if (wr_valid === 1'b1) n_wr++;
    if (crc_err === 1'b1) n_crc++;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait for an answer or for the command port to free up
  task automatic wait_sig(input bit want_ack);
    int n;
    for (n = 0; n < 250000; n++) begin
      @(negedge clk_sys_i);
      if (want_ack ? rd_valid === 1'b1 : cmd_ready === 1'b1) return;
    end
    error_cnt++;
    $display("Error wait timed out");
    finish_test();
  endtask
  // one command through the valid/ready handshake
  task automatic cmd(input mpl_cmd_t k, input logic [ADDR_W-1:0] a, input logic [ACC_DATA_W-1:0] d);
    wait_sig(1'b0);
    @(posedge clk_sys_i);
    #1;
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_data = d;
    @(posedge clk_sys_i);
    #1;
    cmd_valid = 1'b0;
  endtask
  // unlock, read at a slower rate, write with pulses, disable and enable
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    cmd(CMD_ACCESS, ADDR_ACCESS, ACCESS_CODE);
    wait_sig(1'b0);
    chk("unlocked", 16'(unlocked), 16'h1);
    chk("late", 16'(acc_late), 16'h0);
    half_bit = 15'h2bc;
    rd_word = 16'hc35a;
    cmd(CMD_READ, 6'h05, 30'h0);
    wait_sig(1'b1);
    chk("rd_data", rd_data, 16'hc35a);
    chk("rd_err", 16'(rd_err), 16'h0);
    chk("rd_addr", 16'(rd_addr), 16'h5);
    repeat (5600) @(negedge clk_sys_i);
    chk("restore", 16'(i_mpl_if.dev_oe), 16'h1);
    half_bit = 15'h1f4;
    cmd(CMD_WRITE, 6'h11, 30'h9e27);
    wait_sig(1'b0);
    chk("wr_addr", 16'(wr_addr), 16'h11);
    chk("wr_data", wr_data, 16'h9e27);
    cmd(CMD_DIS, ADDR_DIS, 30'h0);
    wait_sig(1'b0);
    chk("dis", {14'h0, out_dis, i_mpl_if.dev_oe}, 16'h2);
    cmd(CMD_EN, ADDR_EN, 30'h0);
    wait_sig(1'b0);
    chk("en", {14'h0, out_dis, i_mpl_if.dev_oe}, 16'h1);
    chk("acks", 16'(n_ack), 16'h1);
    chk("reqs", {n_rd[7:0], n_wr[7:0]}, 16'h0101);
    chk("crc_err", 16'(n_crc), 16'h0);
    finish_test();
  end
endmodule
`default_nettype wire
